// ---- rtl/ctm_map.vh ----
// Purpose: Register offsets, field positions and reset values for the CAN time-out,
//          error-test and acceptance filter block.
// Assumes: APB byte addresses, one 32-bit register per aligned word.
// Notes:   Definitions only.
`ifndef CTM_MAP_VH
`define CTM_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Control region offsets
`define CTM_ADDR_W 14
`define CTM_OFF_MODE 14'h0000
`define CTM_OFF_SHARED_MASK 14'h0024
`define CTM_OFF_NET_TIME 14'h004C
`define CTM_OFF_TO_ENABLE 14'h0050
`define CTM_OFF_TO_FLAGS 14'h0054
`define CTM_OFF_ERR_CTRL 14'h0058
`define CTM_OFF_COMPAT_LOW 14'h0080
`define CTM_OFF_COMPAT_UP 14'h008C

////////////////////////////////////////////////////////////////////////////////
// Mailbox memory: base, per-object slot, word offsets, per-object arrays
`define CTM_MBX_BASE 14'h2000
`define CTM_MBX_SLOT 14'h0010
`define CTM_MBX_ID_WORD 2'h0
`define CTM_MBX_CTRL_WORD 2'h1
`define CTM_MBX_DLO_WORD 2'h2
`define CTM_MBX_DHI_WORD 2'h3
`define CTM_MBX_MASKS 14'h1000
`define CTM_MBX_STAMPS 14'h1080
`define CTM_MBX_TIMEOUTS 14'h1100
`define CTM_MBX_ARRAY_SPAN 14'h0080

////////////////////////////////////////////////////////////////////////////////
// Mode register fields
`define CTM_MODE_LEGACY 0
`define CTM_MODE_SOFT_RST 1
`define CTM_MODE_RESET 32'h0000_0001

////////////////////////////////////////////////////////////////////////////////
// Error test control fields
`define CTM_ETC_FORM 24
`define CTM_ETC_BIT 23
`define CTM_ETC_STUCK 22
`define CTM_ETC_CRC 21
`define CTM_ETC_STUFF 20
`define CTM_ETC_KEY_HI 11
`define CTM_ETC_KEY_LO 8
`define CTM_ETC_SEL_HI 7
`define CTM_ETC_SEL_LO 4
`define CTM_ETC_WMASK 32'h01F0_0FF0
`define CTM_ETC_RESET 32'h0000_0500
`define CTM_ETC_UNLOCK 4'h5

////////////////////////////////////////////////////////////////////////////////
// Frame field codes
`define CTM_FLD_NONE 4'h0
`define CTM_FLD_BASE_ID 4'h1
`define CTM_FLD_LEN 4'h2
`define CTM_FLD_DATA 4'h3
`define CTM_FLD_CRC 4'h4
`define CTM_FLD_CRC_DEL 4'h5
`define CTM_FLD_ACK_SLOT 4'h6
`define CTM_FLD_ACK_DEL 4'h7
`define CTM_FLD_EOF 4'h8
`define CTM_FLD_EXT_ID 4'h9

////////////////////////////////////////////////////////////////////////////////
// Mask and identifier word fields
`define CTM_MASK_FMT 31
`define CTM_MASK_WMASK 32'h9FFF_FFFF
`define CTM_ID_EXT 31
`define CTM_ID_MASK_USE 30
`define CTM_STD_ID_LO 18
`define CTM_COMPAT_LOW_LAST 2
`define CTM_COMPAT_UP_LAST 5

`endif

// ---- rtl/ctm_accept.v ----
// Purpose: Acceptance compare of one received identifier against one mailbox.
// Assumes: Identifier word and mask word already selected by the caller.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "ctm_map.vh"

module ctm_accept (
	input wire [31:0] object_identifier_word,
	input wire [31:0] mask_word,
	input wire [28:0] rx_id,
	input wire rx_ext,
	output wire hit
);

////////////////////////////////////////////////////////////////////////////////
// Mask applies only when the mailbox asks for it
wire mask_use_bit = object_identifier_word[`CTM_ID_MASK_USE];
wire [28:0] care = mask_use_bit ? ~mask_word[28:0] : {29{1'b1}};
wire mask_format_override = mask_use_bit & mask_word[`CTM_MASK_FMT];
// Standard frames only look at the top eleven identifier bits
wire [28:0] span = rx_ext ? {29{1'b1}} : {{11{1'b1}}, 18'h0_0000};
wire [28:0] diff = (rx_id ^ object_identifier_word[28:0]) & care & span;
wire fmt_ok = mask_format_override | (object_identifier_word[`CTM_ID_EXT] == rx_ext);

assign hit = fmt_ok & (diff == 29'h0000_0000);

endmodule // ctm_accept

// ---- rtl/ctm_inject.v ----
// Purpose: Error injection on the received bit stream for self-test.
// Assumes: Field code and stuff marker come from the protocol engine.
// Notes:   Combinational; the caller registers the outputs.
`timescale 1ns/1ps
`include "ctm_map.vh"

module ctm_inject (
	input wire test_on,
	input wire form_err_inject,
	input wire bit_err_inject,
	input wire stuck_dominant_inject,
	input wire crc_err_inject,
	input wire stuff_err_inject,
	input wire [3:0] field_sel,
	input wire [3:0] field_now,
	input wire rx_bit,
	input wire rx_is_stuff,
	input wire transmitting,
	output wire form_bit,
	output wire monitor_bit,
	output wire crc_bit,
	output wire stuff_bit,
	output wire loopback_en
);

////////////////////////////////////////////////////////////////////////////////
// Field qualifiers
wire in_sel = (field_sel == field_now) & (field_sel != `CTM_FLD_NONE);
wire fixed_fld = (field_sel == `CTM_FLD_CRC_DEL) | (field_sel == `CTM_FLD_ACK_DEL) |
	(field_sel == `CTM_FLD_EOF);
wire tx_bit_fld = (field_sel == `CTM_FLD_CRC) | (field_sel == `CTM_FLD_DATA) |
	(field_sel == `CTM_FLD_LEN);
wire crc_fld = (field_sel == `CTM_FLD_BASE_ID) | (field_sel == `CTM_FLD_EXT_ID) |
	(field_sel == `CTM_FLD_DATA) | (field_sel == `CTM_FLD_CRC);
wire stuff_fld = (field_sel == `CTM_FLD_BASE_ID) | (field_sel == `CTM_FLD_EXT_ID) |
	(field_sel == `CTM_FLD_DATA);
wire bit_fld = transmitting ? tx_bit_fld : (field_sel == `CTM_FLD_ACK_SLOT);

////////////////////////////////////////////////////////////////////////////////
// Corrupted copies of the bit for each checker
wire stuck = test_on & stuck_dominant_inject;
wire base = stuck ? 1'b0 : rx_bit;
assign form_bit = base ^ (test_on & form_err_inject & in_sel & fixed_fld);
assign monitor_bit = base ^ (test_on & bit_err_inject & in_sel & bit_fld);
assign crc_bit = (test_on & crc_err_inject & in_sel & crc_fld) ? 1'b0 : base;
assign stuff_bit = base ^ (test_on & stuff_err_inject & in_sel & stuff_fld & rx_is_stuff);
// Loopback unless receive-side bit error or CRC error is being tested
assign loopback_en = test_on & ~(bit_err_inject & ~transmitting) & ~crc_err_inject;

endmodule // ctm_inject

// ---- rtl/ctm_top.v ----
// Purpose: Network time counter with per-mailbox time-outs, error test injection,
//          legacy acceptance filtering and the mailbox memory map, behind APB.
// Assumes: Protocol engine supplies field codes, time ticks and stamp strobes.
// Notes:   Every APB access completes with no wait state; pslverr flags unmapped offsets.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ctm_map.vh"

module ctm_top #(
	parameter NUM_OBJ = 32,
	parameter NUM_COMPAT = 16
) (
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire time_tick,
	input wire stamp_strobe,
	input wire [4:0] stamp_object,
	input wire rx_id_valid,
	input wire [28:0] rx_id,
	input wire rx_ext,
	output reg [NUM_COMPAT-1:0] accept_hit,
	input wire [3:0] field_now,
	input wire rx_bit,
	input wire rx_is_stuff,
	input wire transmitting,
	output reg form_bit,
	output reg monitor_bit,
	output reg crc_bit,
	output reg stuff_bit,
	output reg loopback_en,
	output reg [31:0] timeout_flag,
	output reg legacy_compatible_mode
);

////////////////////////////////////////////////////////////////////////////////
// State
reg [31:0] network_time_value;
reg [31:0] timeout_enable;
reg [31:0] err_ctrl_reg;
reg [31:0] shared_mask_reg;
reg [31:0] compat_low_reg;
reg [31:0] compat_up_reg;
reg soft_rst_reg;
// Per-object storage, sized by the object count
reg [31:0] obj_mem [0:NUM_OBJ*4-1];
reg [31:0] object_accept_mask [0:NUM_OBJ-1];
reg [31:0] object_time_stamp [0:NUM_OBJ-1];
reg [31:0] object_timeout_value [0:NUM_OBJ-1];
// Combinational helpers for the read mux and the flags
reg [31:0] rd_next;
reg err_next;
reg [31:0] tos_next;
integer i;

////////////////////////////////////////////////////////////////////////////////
// Address decode
// Only the low fourteen bits are decoded, so the map repeats above 4000h
// Mailbox region starts at 2000h; slot words, then the three per-object arrays
wire [13:0] off = paddr[13:0];
wire setup = psel & ~penable;
wire wr_go = psel & penable & pwrite;
wire in_mbx = (off >= `CTM_MBX_BASE);
wire [13:0] moff = off - `CTM_MBX_BASE;
wire mbx_slots = in_mbx & (moff < `CTM_MBX_MASKS);
wire mbx_masks = in_mbx & (moff >= `CTM_MBX_MASKS) & (moff < `CTM_MBX_STAMPS);
wire mbx_stamps = in_mbx & (moff >= `CTM_MBX_STAMPS) & (moff < `CTM_MBX_TIMEOUTS);
wire mbx_touts = in_mbx & (moff >= `CTM_MBX_TIMEOUTS) &
	(moff < `CTM_MBX_TIMEOUTS + `CTM_MBX_ARRAY_SPAN);
wire [6:0] slot_word = moff[8:2];
wire [4:0] arr_idx = moff[6:2];
wire slot_ok = mbx_slots & (moff < NUM_OBJ * `CTM_MBX_SLOT);
wire arr_ok = (mbx_masks | mbx_stamps | mbx_touts) & ({2'b00, arr_idx} < NUM_OBJ);
// Enhanced-only registers answer with an error while legacy mode is on
wire enh_ok = ~legacy_compatible_mode;

// No wait state: data is gathered on the setup edge
assign pready = penable;

////////////////////////////////////////////////////////////////////////////////
// Read mux and unmapped detection
// Misaligned offsets always error, whatever region they fall in
// Enhanced-only registers read zero and error in legacy mode
always @* begin
	rd_next = 32'h0000_0000;
	err_next = 1'b0;
	if (off[1:0] != 2'b00) begin
		err_next = 1'b1;
	end else if (slot_ok) begin
		rd_next = obj_mem[slot_word];
	end else if (arr_ok & mbx_masks) begin
		rd_next = object_accept_mask[arr_idx];
	end else if (arr_ok & mbx_stamps) begin
		rd_next = object_time_stamp[arr_idx];
	end else if (arr_ok & mbx_touts) begin
		rd_next = object_timeout_value[arr_idx];
	end else begin
		case (off)
			`CTM_OFF_MODE: rd_next = {30'h0000_0000, 1'b0, legacy_compatible_mode};
			`CTM_OFF_SHARED_MASK: rd_next = shared_mask_reg;
			`CTM_OFF_COMPAT_LOW: rd_next = compat_low_reg;
			`CTM_OFF_COMPAT_UP: rd_next = compat_up_reg;
			`CTM_OFF_ERR_CTRL: rd_next = err_ctrl_reg;
			`CTM_OFF_NET_TIME: begin
				rd_next = enh_ok ? network_time_value : 32'h0000_0000;
				err_next = ~enh_ok;
			end
			`CTM_OFF_TO_ENABLE: begin
				rd_next = enh_ok ? timeout_enable : 32'h0000_0000;
				err_next = ~enh_ok;
			end
			`CTM_OFF_TO_FLAGS: begin
				rd_next = enh_ok ? timeout_flag : 32'h0000_0000;
				err_next = ~enh_ok;
			end
			default: err_next = 1'b1;
		endcase
	end
end

// Capture read data and error at the setup edge
// Data then stands through the access phase, so the read is taken at pready
// A write cycle leaves zero on the read bus
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		prdata <= 32'h0000_0000;
		pslverr <= 1'b0;
	end else if (setup) begin
		prdata <= pwrite ? 32'h0000_0000 : rd_next;
		pslverr <= err_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers
// Mode bit 0 selects legacy mode and resets to one
// Mode bit 1 is a one-cycle soft reset of the legacy masks and reads zero
// Mask writes drop bits 30-29, error control keeps only its defined fields
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		legacy_compatible_mode <= 1'b1;
		soft_rst_reg <= 1'b0;
		shared_mask_reg <= 32'h0000_0000;
		err_ctrl_reg <= `CTM_ETC_RESET;
		timeout_enable <= 32'h0000_0000;
	end else begin
		soft_rst_reg <= 1'b0;
		if (wr_go) begin
			case (off)
				`CTM_OFF_MODE: begin
					legacy_compatible_mode <= pwdata[`CTM_MODE_LEGACY];
					soft_rst_reg <= pwdata[`CTM_MODE_SOFT_RST];
				end
				`CTM_OFF_SHARED_MASK: shared_mask_reg <= pwdata & `CTM_MASK_WMASK;
				`CTM_OFF_ERR_CTRL: err_ctrl_reg <= pwdata & `CTM_ETC_WMASK;
				`CTM_OFF_TO_ENABLE: if (enh_ok) timeout_enable <= pwdata;
				default: ;
			endcase
		end
	end
end

// Legacy local masks, also cleared by the legacy soft reset
// Soft reset wins over a write landing in the same cycle
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		compat_low_reg <= 32'h0000_0000;
		compat_up_reg <= 32'h0000_0000;
	end else if (soft_rst_reg) begin
		compat_low_reg <= 32'h0000_0000;
		compat_up_reg <= 32'h0000_0000;
	end else if (wr_go && off == `CTM_OFF_COMPAT_LOW) begin
		compat_low_reg <= pwdata & `CTM_MASK_WMASK;
	end else if (wr_go && off == `CTM_OFF_COMPAT_UP) begin
		compat_up_reg <= pwdata & `CTM_MASK_WMASK;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Network time counter: software write wins over the tick
// The counter only runs in enhanced mode and wraps silently at the top
// A tick in the same cycle as a write is lost
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		network_time_value <= 32'h0000_0000;
	end else if (wr_go && enh_ok && off == `CTM_OFF_NET_TIME) begin
		network_time_value <= pwdata;
	end else if (time_tick && enh_ok) begin
		network_time_value <= network_time_value + 32'h0000_0001;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Time-out flags: compare every cycle, set wins over clear
// Comparing every cycle covers ticks and software writes of the counter alike
// A flag cleared while its condition still holds stays set, as the set wins at the same edge
always @* begin
	tos_next = timeout_flag;
	if (wr_go && enh_ok && off == `CTM_OFF_TO_FLAGS) begin
		tos_next = timeout_flag & ~pwdata;
	end
	for (i = 0; i < NUM_OBJ; i = i + 1) begin
		if (enh_ok && timeout_enable[i] &&
			network_time_value >= object_timeout_value[i]) begin
			tos_next[i] = 1'b1;
		end
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		timeout_flag <= 32'h0000_0000;
	end else begin
		timeout_flag <= tos_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Mailbox memory and per-object arrays; stamps take the counter value
// No reset here: the words are written by software before use
// A stamp strobe wins over a software write to the stamp array
always @(posedge clk) begin
	if (wr_go && off[1:0] == 2'b00 && slot_ok) begin
		obj_mem[slot_word] <= pwdata;
	end
	if (wr_go && off[1:0] == 2'b00 && arr_ok && mbx_masks) begin
		object_accept_mask[arr_idx] <= pwdata;
	end
	if (wr_go && off[1:0] == 2'b00 && arr_ok && mbx_touts) begin
		object_timeout_value[arr_idx] <= pwdata;
	end
	if (stamp_strobe && {2'b00, stamp_object} < NUM_OBJ) begin
		object_time_stamp[stamp_object] <= network_time_value;
	end else if (wr_go && off[1:0] == 2'b00 && arr_ok && mbx_stamps) begin
		object_time_stamp[arr_idx] <= pwdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Legacy acceptance filtering
// Each of the sixteen legacy mailboxes has its own comparator
// Mailbox identifier words sit in slot word 0 of each object
wire [NUM_COMPAT-1:0] hit_now;
genvar g;
generate
	for (g = 0; g < NUM_COMPAT; g = g + 1) begin : g_acc
		// Mask choice by mailbox number
		wire [31:0] sel_mask = (g <= `CTM_COMPAT_LOW_LAST) ? compat_low_reg :
			(g <= `CTM_COMPAT_UP_LAST) ? compat_up_reg : shared_mask_reg;
		ctm_accept u_acc (
			.object_identifier_word(obj_mem[g*4]),
			.mask_word(sel_mask),
			.rx_id(rx_id),
			.rx_ext(rx_ext),
			.hit(hit_now[g])
		);
	end
endgenerate

// Hits are registered per received identifier
// Enhanced mode gives no hits, as its filtering is not built here
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		accept_hit <= {NUM_COMPAT{1'b0}};
	end else if (rx_id_valid) begin
		accept_hit <= legacy_compatible_mode ? hit_now : {NUM_COMPAT{1'b0}};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Error test injection
// Test mode is on only while the key field holds five; the key resets to five
wire test_on = (err_ctrl_reg[`CTM_ETC_KEY_HI:`CTM_ETC_KEY_LO] == `CTM_ETC_UNLOCK);
wire inj_form;
wire inj_mon;
wire inj_crc;
wire inj_stuff;
wire inj_loop;

ctm_inject u_inj (
	.test_on(test_on),
	.form_err_inject(err_ctrl_reg[`CTM_ETC_FORM]),
	.bit_err_inject(err_ctrl_reg[`CTM_ETC_BIT]),
	.stuck_dominant_inject(err_ctrl_reg[`CTM_ETC_STUCK]),
	.crc_err_inject(err_ctrl_reg[`CTM_ETC_CRC]),
	.stuff_err_inject(err_ctrl_reg[`CTM_ETC_STUFF]),
	.field_sel(err_ctrl_reg[`CTM_ETC_SEL_HI:`CTM_ETC_SEL_LO]),
	.field_now(field_now),
	.rx_bit(rx_bit),
	.rx_is_stuff(rx_is_stuff),
	.transmitting(transmitting),
	.form_bit(inj_form),
	.monitor_bit(inj_mon),
	.crc_bit(inj_crc),
	.stuff_bit(inj_stuff),
	.loopback_en(inj_loop)
);

// Checker-facing bits leave from flip-flops
// Reset values are recessive bits and no loopback
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		form_bit <= 1'b1;
		monitor_bit <= 1'b1;
		crc_bit <= 1'b1;
		stuff_bit <= 1'b1;
		loopback_en <= 1'b0;
	end else begin
		form_bit <= inj_form;
		monitor_bit <= inj_mon;
		crc_bit <= inj_crc;
		stuff_bit <= inj_stuff;
		loopback_en <= inj_loop;
	end
end

endmodule // ctm_top

// ---- tb/ctm_top_props.sv ----
// Purpose: Port-level checks on time-outs, error injection and filtering.
// Assumes: Shadows of the test control and enable words follow APB writes.
// Notes: Bound to every ctm_top instance.
`timescale 1ns/1ps

module ctm_top_props #(
	parameter NUM_COMPAT = 16
) (
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [NUM_COMPAT-1:0] accept_hit,
	input wire rx_id_valid,
	input wire [3:0] field_now,
	input wire rx_bit,
	input wire rx_is_stuff,
	input wire transmitting,
	input wire form_bit,
	input wire monitor_bit,
	input wire crc_bit,
	input wire stuff_bit,
	input wire loopback_en,
	input wire [31:0] timeout_flag,
	input wire legacy_compatible_mode
);
////////////////////////////////////////
// Shadows of the test control word and time-out enables
reg [31:0] etc_reg;
reg [31:0] ten_reg;
wire wr = psel && penable && pwrite;
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		etc_reg <= 32'h0000_0500;
		ten_reg <= 32'h0;
	end else begin
		if (wr && paddr[13:0] == 14'h0058)
			etc_reg <= pwdata & 32'h01F0_0FF0;
		if (wr && paddr[13:0] == 14'h0050 && !legacy_compatible_mode)
			ten_reg <= pwdata;
	end
end
// Decoded test state; stuck injection clears the bit, the flips then act on it
wire test_on = etc_reg[11:8] == 4'h5;
wire sel_now = test_on && etc_reg[7:4] == field_now;
wire stuck_on = test_on && etc_reg[22];
wire base_b = stuck_on ? 1'b0 : rx_bit;
wire f_form = sel_now && etc_reg[24] && field_now inside {4'h5, 4'h7, 4'h8};
wire f_mon = sel_now && etc_reg[23] &&
	(transmitting ? field_now inside {4'h2, 4'h3, 4'h4} : field_now == 4'h6);
wire f_stuff = sel_now && etc_reg[20] && rx_is_stuff && field_now inside {4'h1, 4'h3, 4'h9};
wire lb_want = test_on && !etc_reg[21] && !(etc_reg[23] && !transmitting);

////////////////////////////////////////
default clocking @(posedge clk); endclocking
default disable iff (!rstn);

a_inject_idle: assert property (!test_on |=> !loopback_en &&
	{form_bit, monitor_bit, crc_bit, stuff_bit} == {4{$past(rx_bit)}}) else $error("inject idle");
a_stuck_low: assert property (stuck_on |=>
	{form_bit, monitor_bit, crc_bit, stuff_bit} ==
	{$past(f_form), $past(f_mon), 1'b0, $past(f_stuff)}) else $error("stuck not low");
a_form_flip: assert property (f_form |=>
	form_bit == !$past(base_b)) else $error("form bit");
a_bit_flip: assert property (f_mon |=>
	monitor_bit == !$past(base_b)) else $error("monitor bit");
a_crc_mask: assert property (sel_now && etc_reg[21] && field_now inside {4'h1, 4'h3, 4'h4, 4'h9}
	|=> !crc_bit) else $error("crc bit");
a_stuff_flip: assert property (f_stuff |=>
	stuff_bit == !$past(base_b)) else $error("stuff bit");
a_loop_on: assert property (1'b1 |=> loopback_en == $past(lb_want)) else $error("loopback");
a_flag_hold: assert property (!(wr && paddr[13:0] == 14'h0054) |=>
	($past(timeout_flag) & ~timeout_flag) == 32'h0) else $error("flag dropped");
a_flag_enable: assert property (1'b1 |=>
	(timeout_flag & ~$past(timeout_flag) & ~$past(ten_reg)) == 32'h0) else $error("flag set");
a_hit_enh_zero: assert property (rx_id_valid && !legacy_compatible_mode |=>
	accept_hit == '0) else $error("hit in enhanced");

c_form: cover property (sel_now && etc_reg[24] && field_now == 4'h8);
c_flag: cover property (timeout_flag != 32'h0);
c_hit: cover property (legacy_compatible_mode && accept_hit != '0);
endmodule // ctm_top_props

bind ctm_top ctm_top_props #(.NUM_COMPAT(NUM_COMPAT)) u_props (.clk, .rstn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .accept_hit, .rx_id_valid, .field_now, .rx_bit, .rx_is_stuff,
	.transmitting, .form_bit, .monitor_bit, .crc_bit, .stuff_bit, .loopback_en, .timeout_flag,
	.legacy_compatible_mode);

// ---- tb/ctm_can_node.sv ----
// Purpose: Bus-side stand-in giving received bits and frame field codes.
// Assumes: Four clocks per field, recessive between frames.
// Notes: Direction alternates frame by frame.
`timescale 1ns/1ps

module ctm_can_node (
	input wire clk,
	input wire rstn,
	output logic [3:0] field_now,
	output logic rx_bit,
	output logic rx_is_stuff,
	output logic transmitting
);
integer seed = 32'hCF33;
logic [31:0] r;
logic [5:0] step;
////////////////////////////////////////
// Walk the field codes, then idle recessive
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		step <= 6'h0;
		field_now <= 4'h0;
		rx_bit <= 1'b1;
		rx_is_stuff <= 1'b0;
		transmitting <= 1'b0;
	end else begin
		r = $random(seed);
		step <= step + 6'h1;
		field_now <= step[5:2] < 4'hA ? step[5:2] : 4'h0;
		rx_bit <= step[5:2] == 4'h0 || step[5:2] > 4'h9 ? 1'b1 : r[0];
		rx_is_stuff <= step[5:2] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h9} && r[2:1] == 2'h0;
		if (step == 6'h3F)
			transmitting <= !transmitting;
	end
end
endmodule // ctm_can_node

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the time-out, error test and filter block.
// Assumes: APB answers with no wait state.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ps

module tb_top;
logic clk = 1'b0, rstn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, timeout_flag, rd, t0, v;
logic time_tick = 1'b0, stamp_strobe = 1'b0, rx_id_valid = 1'b0, rx_ext = 1'b0;
logic [4:0] stamp_object = 5'h0;
logic [28:0] rx_id = 29'h0;
logic [15:0] accept_hit;
logic [3:0] field_now;
logic pready, pslverr, rx_bit, rx_is_stuff, transmitting, form_bit, monitor_bit, crc_bit;
logic stuff_bit, loopback_en, legacy_compatible_mode, er;
logic [31:0] idw [16];
logic [31:0] m [3];
logic [31:0] val [7];
integer seed = 32'hCF33;
int n_fail = 0, cmp_count = 0;

////////////////////////////////////////
// Clock, block and bus-side node
always #20 clk = ~clk;
ctm_top dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.time_tick, .stamp_strobe, .stamp_object, .rx_id_valid, .rx_id, .rx_ext, .accept_hit,
	.field_now, .rx_bit, .rx_is_stuff, .transmitting, .form_bit, .monitor_bit, .crc_bit,
	.stuff_bit, .loopback_en, .timeout_flag, .legacy_compatible_mode);
ctm_can_node node (.clk, .rstn, .field_now, .rx_bit, .rx_is_stuff, .transmitting);

////////////////////////////////////////
task automatic end_of_test;
	$display("compares %0d mismatches %0d", cmp_count, n_fail);
	if (n_fail == 0 && cmp_count > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	cmp_count++;
	if (got !== exp) begin
		n_fail++;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	end
endtask
// One APB transfer, held until pready is seen high
task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
	int k;
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'b1;
	k = 0;
	do begin
		@(posedge clk);
		k++;
	end while (pready !== 1'b1 && k < 16);
	if (pready !== 1'b1) begin
		n_fail++;
		end_of_test;
	end
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge clk);
endtask
task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic e);
	apb(1'b0, a, 32'h0);
	chk(rd, exp);
	chk({31'h0, er}, {31'h0, e});
endtask
task automatic tick(input int n);
	repeat (n) begin
		time_tick <= 1'b1;
		@(posedge clk);
		time_tick <= 1'b0;
		@(posedge clk);
	end
endtask
// Slot words 0-3, then mask, stamp and time-out arrays
function automatic logic [31:0] maddr(input int n, input int k);
	if (k < 4)
		return 32'h2000 + n * 32'h10 + k * 32'h4;
	return 32'h3000 + (k - 4) * 32'h80 + n * 32'h4;
endfunction
function automatic logic hitf(input logic [31:0] w, input logic [31:0] k, input logic [28:0] id,
	input logic ext);
	logic [28:0] care;
	care = (w[30] ? ~k[28:0] : 29'h1FFF_FFFF) & (ext ? 29'h1FFF_FFFF : 29'h1FFC_0000);
	return (w[30] && k[31] || ext == w[31]) && ((id ^ w[28:0]) & care) == 29'h0;
endfunction
task automatic frame(input logic [28:0] id, input logic ext);
	logic [15:0] exp;
	for (int j = 0; j < 16; j++)
		exp[j] = legacy_compatible_mode === 1'b1 && hitf(idw[j], m[j < 3 ? 0 : j < 6 ? 1 : 2], id, ext);
	rx_id_valid <= 1'b1;
	rx_id <= id;
	rx_ext <= ext;
	@(posedge clk);
	rx_id_valid <= 1'b0;
	repeat (2) @(posedge clk);
	chk({16'h0, accept_hit}, {16'h0, exp});
endtask

////////////////////////////////////////
// Main sequence
initial begin
	rstn <= 1'b0;
	repeat (8) @(posedge clk);
	rstn <= 1'b1;
	@(posedge clk);
	chk({31'h0, legacy_compatible_mode}, 32'h1);
	rdc(32'h80, 32'h0, 1'b0);
	rdc(32'h8C, 32'h0, 1'b0);
	rdc(32'h58, 32'h500, 1'b0);
	rdc(32'h54, 32'h0, 1'b1);
	rdc(32'h0FF0, 32'h0, 1'b1);
	rdc(32'h82, 32'h0, 1'b1);
	apb(1'b1, 32'h50, 32'hFFFF_FFFF);
	apb(1'b1, 32'h0, 32'h0);
	rdc(32'h50, 32'h0, 1'b0);
	$display("test reset done");
	for (int t = 0; t < 4; t++) begin
		for (int k = 0; k < 7; k++) begin
			val[k] = $random(seed) & 32'h9FFF_FFFF;
			apb(1'b1, maddr(t == 0 ? 31 : t * 7, k), val[k]);
		end
		for (int k = 0; k < 7; k++)
			rdc(maddr(t == 0 ? 31 : t * 7, k), val[k], 1'b0);
	end
	$display("test map done");
	t0 = $random(seed) & 32'h7FFF_FFF0;
	apb(1'b1, 32'h4C, t0);
	rdc(32'h4C, t0, 1'b0);
	apb(1'b1, maddr(5, 6), t0 + 32'h3);
	apb(1'b1, maddr(9, 6), t0 + 32'h2);
	apb(1'b1, 32'h50, 32'h20);
	tick(2);
	chk(timeout_flag, 32'h0);
	tick(1);
	repeat (2) @(posedge clk);
	chk(timeout_flag, 32'h20);
	rdc(32'h4C, t0 + 32'h3, 1'b0);
	stamp_strobe <= 1'b1;
	stamp_object <= 5'h3;
	@(posedge clk);
	stamp_strobe <= 1'b0;
	@(posedge clk);
	rdc(maddr(3, 5), t0 + 32'h3, 1'b0);
	apb(1'b1, 32'h54, 32'hFFFF_FFDF);
	rdc(32'h54, 32'h20, 1'b0);
	apb(1'b1, 32'h50, 32'h0);
	apb(1'b1, 32'h54, 32'h20);
	rdc(32'h54, 32'h0, 1'b0);
	frame(29'h0, 1'b0);
	$display("test timeout done");
	apb(1'b1, 32'h0, 32'h1);
	for (int j = 0; j < 3; j++) begin
		m[j] = $random(seed) | $random(seed);
		apb(1'b1, j == 0 ? 32'h80 : j == 1 ? 32'h8C : 32'h24, m[j]);
	end
	rdc(32'h8C, m[1] & 32'h9FFF_FFFF, 1'b0);
	for (int j = 0; j < 16; j++) begin
		idw[j] = $random(seed);
		apb(1'b1, maddr(j, 0), idw[j]);
	end
	for (int f = 0; f < 40; f++) begin
		v = $random(seed) & 32'hF;
		frame(idw[v][28:0] ^ 29'($random(seed) & $random(seed) & $random(seed)),
			f[0] ? idw[v][31] : v[0]);
	end
	apb(1'b1, 32'h0, 32'h3);
	rdc(32'h80, 32'h0, 1'b0);
	rdc(32'h8C, 32'h0, 1'b0);
	$display("test filter done");
	for (int s = 0; s < 32; s++) begin
		v = $random(seed);
		v[7:4] = s[4:1];
		v[22] = v[22] & v[0];
		if (s % 4 != 3)
			v[11:8] = 4'h5;
		apb(1'b1, 32'h58, v);
		rdc(32'h58, v & 32'h01F0_0FF0, 1'b0);
		repeat (64) @(posedge clk);
	end
	$display("test inject done");
	end_of_test;
end
endmodule // tb_top
